// file: blse_evaluator.sv
// Bit-logic stack evaluator: one instruction per cycle against a one-bit stack top.
// Assumes the scan executor is on core_clk; physical input pins are asynchronous.

`timescale 1ns/1ps
`default_nettype none

module blse_evaluator (
	input  wire logic                         core_clk,
	input  wire logic                         srst,
	input  wire logic                         instr_valid,
	input  wire blse_pkg::blse_instr_t        instr,
	input  wire blse_pkg::blse_image_t        image,
	input  wire logic [blse_pkg::PIN_W-1:0]   phys_pins,
	input  wire logic                         scan_strobe,
	output logic                              stack_top,
	output logic                              term_overflow,
	output logic                              instr_done
);

	// ==========================================
	// Pin synchroniser
	// Pins are asynchronous; sample only after two flops
	logic [blse_pkg::PIN_W-1:0] pin_meta_q;
	logic [blse_pkg::PIN_W-1:0] pin_sync_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= phys_pins;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================
	// Operand resolution
	function automatic logic combine(input logic [1:0] mode, input logic top, input logic v);
		unique case (mode)
			2'h0:    combine = v;
			2'h1:    combine = top & v;
			default: combine = top | v;
		endcase
	endfunction

	logic [blse_pkg::PIN_W-1:0] pin_now;
	logic                       operand;
	logic                       imm_bit;
	logic                       stack_top_q;
	logic                       stack_top_d;
	logic [blse_pkg::EDGE_SLOTS-1:0] prev_q;
	logic                       prev_sel;

	assign pin_now  = pin_sync_q;
	assign prev_sel = prev_q[instr.edge_idx];

	always_comb begin
		unique case (instr.src)
			blse_pkg::BLSE_SRC_INPUT_IMAGE:  operand = image.input_image[instr.pin_idx];
			blse_pkg::BLSE_SRC_OUTPUT_IMAGE: operand = image.output_image[instr.pin_idx];
			blse_pkg::BLSE_SRC_MEMORY:       operand = instr.mem_bit;
			default:                         operand = instr.mem_bit;
		endcase
	end

	// Image is an input here; the block has no path to write it
	assign imm_bit = pin_now[instr.pin_idx];

	// ==========================================
	// Stack top evaluation
	always_comb begin
		stack_top_d = stack_top_q;
		if (instr_valid) begin
			unique case (instr.op)
				blse_pkg::BLSE_NOP:          stack_top_d = stack_top_q;
				blse_pkg::BLSE_LOAD_BIT:     stack_top_d = combine(2'h0, stack_top_q, operand);
				blse_pkg::BLSE_AND_BIT:      stack_top_d = combine(2'h1, stack_top_q, operand);
				blse_pkg::BLSE_OR_BIT:       stack_top_d = combine(2'h2, stack_top_q, operand);
				blse_pkg::BLSE_LOAD_NOT_BIT: stack_top_d = combine(2'h0, stack_top_q, ~operand);
				blse_pkg::BLSE_AND_NOT_BIT:  stack_top_d = combine(2'h1, stack_top_q, ~operand);
				blse_pkg::BLSE_OR_NOT_BIT:   stack_top_d = combine(2'h2, stack_top_q, ~operand);
				blse_pkg::BLSE_LOAD_IMMEDIATE:
					stack_top_d = combine(2'h0, stack_top_q, imm_bit);
				blse_pkg::BLSE_AND_IMMEDIATE:
					stack_top_d = combine(2'h1, stack_top_q, imm_bit);
				blse_pkg::BLSE_OR_IMMEDIATE:
					stack_top_d = combine(2'h2, stack_top_q, imm_bit);
				blse_pkg::BLSE_LOAD_INVERTED_IMMEDIATE:
					stack_top_d = combine(2'h0, stack_top_q, ~imm_bit);
				blse_pkg::BLSE_AND_INVERTED_IMMEDIATE:
					stack_top_d = combine(2'h1, stack_top_q, ~imm_bit);
				blse_pkg::BLSE_OR_INVERTED_IMMEDIATE:
					stack_top_d = combine(2'h2, stack_top_q, ~imm_bit);
				blse_pkg::BLSE_INVERT_TOP:   stack_top_d = ~stack_top_q;
				blse_pkg::BLSE_RISING_EDGE_DETECT:
					stack_top_d = stack_top_q & ~prev_sel;
				blse_pkg::BLSE_FALLING_EDGE_DETECT:
					stack_top_d = ~stack_top_q & prev_sel;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stack_top_q <= blse_pkg::TOS_RESET;
		end else begin
			stack_top_q <= stack_top_d;
		end
	end

	assign stack_top = stack_top_q;

	// ==========================================
	// Edge history, one slot per instruction instance
	logic is_edge;

	assign is_edge = instr_valid && (instr.op == blse_pkg::BLSE_RISING_EDGE_DETECT
		|| instr.op == blse_pkg::BLSE_FALLING_EDGE_DETECT);

	// Cleared at reset so the first scan never reports an edge from a stale 1
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prev_q <= {blse_pkg::EDGE_SLOTS{blse_pkg::PREV_RESET}};
		end else if (is_edge) begin
			prev_q[instr.edge_idx] <= stack_top_q;
		end
	end

	// ==========================================
	// Term counter for a combined AND/OR chain
	// Counts terms after a load; the issuer must split past seven
	logic [blse_pkg::TERM_CNT_W-1:0] terms_q;
	logic                            is_load;
	logic                            is_comb;
	logic                            term_overflow_q;

	assign is_load = instr_valid && (instr.op == blse_pkg::BLSE_LOAD_BIT
		|| instr.op == blse_pkg::BLSE_LOAD_NOT_BIT
		|| instr.op == blse_pkg::BLSE_LOAD_IMMEDIATE
		|| instr.op == blse_pkg::BLSE_LOAD_INVERTED_IMMEDIATE);
	assign is_comb = instr_valid && !is_load && !is_edge
		&& instr.op != blse_pkg::BLSE_NOP && instr.op != blse_pkg::BLSE_INVERT_TOP;

	always_ff @(posedge core_clk) begin
		if (srst || scan_strobe) begin
			terms_q <= '0;
		end else if (is_load) begin
			terms_q <= 3'h1;
		end else if (is_comb && terms_q != 3'h7) begin
			terms_q <= terms_q + 3'h1;
		end
	end

	// Sticky within a scan; a new scan clears it unless the breach is in that cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			term_overflow_q <= 1'h0;
		end else if (is_comb && terms_q == 3'h7) begin
			term_overflow_q <= 1'h1;
		end else if (scan_strobe) begin
			term_overflow_q <= 1'h0;
		end
	end

	assign term_overflow = term_overflow_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			instr_done <= 1'h0;
		end else begin
			instr_done <= instr_valid;
		end
	end

	// ==========================================
	// Checks
	sequence s_rise_seen;
		instr_valid && instr.op == blse_pkg::BLSE_RISING_EDGE_DETECT && stack_top_q
			&& !prev_sel;
	endsequence

	AST_RISE_ONE: assert property (@(posedge core_clk) disable iff (srst)
		s_rise_seen |=> stack_top_q) else $error("rise not reported");
	AST_RISE_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_RISING_EDGE_DETECT && prev_sel
		|=> !stack_top_q) else $error("rise reported without edge");
	AST_FALL: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_FALLING_EDGE_DETECT
		|=> stack_top_q == ($past(prev_sel) && !$past(stack_top_q))) else $error("fall wrong");
	AST_INVERT: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_INVERT_TOP
		|=> stack_top_q != $past(stack_top_q)) else $error("invert failed");
	AST_LOAD_OPEN: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_LOAD_BIT
		|=> stack_top_q == $past(operand)) else $error("load wrong");
	AST_LOAD_CLOSED: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_LOAD_NOT_BIT
		|=> stack_top_q == !$past(operand)) else $error("load not wrong");
	AST_AND_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_AND_BIT && !stack_top_q
		|=> !stack_top_q) else $error("and leaked");
	AST_OR_NOT_ONE: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_OR_NOT_BIT && !operand
		|=> stack_top_q) else $error("or not missed");
	AST_IMM_LOAD: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_LOAD_IMMEDIATE
		|=> stack_top_q == $past(pin_sync_q[instr.pin_idx])) else $error("imm load wrong");
	AST_IMM_NOT: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_LOAD_INVERTED_IMMEDIATE
		|=> stack_top_q != $past(imm_bit)) else $error("imm not wrong");
	AST_IMAGE_SRC: assert property (@(posedge core_clk) disable iff (srst)
		instr_valid && instr.op == blse_pkg::BLSE_LOAD_BIT
		&& instr.src == blse_pkg::BLSE_SRC_INPUT_IMAGE
		|=> stack_top_q == $past(image.input_image[instr.pin_idx])) else $error("image not used");
	AST_PREV_KEPT: assert property (@(posedge core_clk) disable iff (srst)
		is_edge |=> prev_q[$past(instr.edge_idx)] == $past(stack_top_q))
		else $error("edge history lost");
	AST_TERMS: assert property (@(posedge core_clk) disable iff (srst)
		is_comb && terms_q == 3'h7 |=> term_overflow_q) else $error("overflow missed");

endmodule // blse_evaluator

`default_nettype wire

// file: blse_evaluator_test.sv
// Self-checking bench for the bit-logic stack evaluator, with a queue-free stack model.
// Assumes blse_exec_model drives the instruction side; the bench drives image and pins.
`timescale 1ns/1ps
`default_nettype none
module blse_evaluator_test;
	logic                  core_clk = 1'h0;
	logic                  srst = 1'h1;
	blse_pkg::blse_image_t image = '0;
	logic [15:0]           phys_pins = 16'h0000;
	logic                  instr_valid, scan_strobe, stack_top, term_overflow, instr_done;
	blse_pkg::blse_instr_t instr, i;
	logic                  tos = 1'h0, ovf = 1'h0;
	logic                  prev [16];
	logic [15:0]           pins_m = 16'h0000;
	int                    cnt = 0, fail_count = 0, total_checks = 0, seed, n;

	always #4 core_clk = ~core_clk;

	blse_exec_model blse_exec_model_i (.core_clk(core_clk), .instr_valid(instr_valid),
		.instr(instr), .scan_strobe(scan_strobe));
	blse_evaluator blse_evaluator_i (.core_clk(core_clk), .srst(srst),
		.instr_valid(instr_valid), .instr(instr), .image(image), .phys_pins(phys_pins),
		.scan_strobe(scan_strobe), .stack_top(stack_top), .term_overflow(term_overflow),
		.instr_done(instr_done));

	// ==========================================
	// Checking and reporting
	task automatic check(input string what, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================
	// Model and drivers
	// Ops 1..12 come in threes: load, and, or; groups plain, not, imm, inverted imm
	task automatic run(input blse_pkg::blse_instr_t x);
		int  o, g, k;
		logic v;
		image = blse_pkg::blse_image_t'($urandom);
		o = int'(x.op);
		if (o >= 1 && o <= 12) begin
			g = (o - 1) / 3;
			k = (o - 1) % 3;
			if (g >= 2)
				v = pins_m[x.pin_idx];
			else if (x.src == blse_pkg::BLSE_SRC_INPUT_IMAGE)
				v = image.input_image[x.pin_idx];
			else if (x.src == blse_pkg::BLSE_SRC_OUTPUT_IMAGE)
				v = image.output_image[x.pin_idx];
			else
				v = x.mem_bit;
			if (g == 1 || g == 3)
				v = ~v;
			if (k == 0) begin
				tos = v;
				cnt = 1;
			end else begin
				tos = (k == 1) ? (tos & v) : (tos | v);
				cnt++;
				if (cnt > blse_pkg::MAX_TERMS)
					ovf = 1'h1;
			end
		end else if (o == 13) begin
			tos = ~tos;
		end else if (o >= 14) begin
			v = (o == 14) ? (tos & ~prev[x.edge_idx]) : (~tos & prev[x.edge_idx]);
			prev[x.edge_idx] = tos;
			tos = v;
		end
		blse_exec_model_i.issue(x);
		check("stack_top", stack_top, tos);
		check("instr_done", instr_done, 1'h1);
		check("term_overflow", term_overflow, ovf);
	endtask
	task automatic op(input blse_pkg::blse_op_t c, input logic b, input logic [3:0] e);
		blse_pkg::blse_instr_t x;
		x = '0;
		x.op = c;
		x.mem_bit = b;
		x.edge_idx = e;
		run(x);
	endtask
	task automatic scan_end();
		blse_exec_model_i.strobe();
		cnt = 0;
		ovf = 1'h0;
		check("term_overflow", term_overflow, 1'h0);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		foreach (prev[j])
			prev[j] = 1'h0;
		seed = $urandom(47);
		repeat (5) @(posedge core_clk);
		#1;
		srst = 1'h0;
		blse_exec_model_i.idle();
		check("stack_top", stack_top, 1'h0);
		check("instr_done", instr_done, 1'h0);
		$display("test reset done");
		// First scan sees an edge from the cleared history, the second does not
		op(blse_pkg::BLSE_LOAD_BIT, 1'h1, 4'h0);
		op(blse_pkg::BLSE_RISING_EDGE_DETECT, 1'h0, 4'h0);
		scan_end();
		op(blse_pkg::BLSE_LOAD_BIT, 1'h1, 4'h0);
		op(blse_pkg::BLSE_RISING_EDGE_DETECT, 1'h0, 4'h0);
		scan_end();
		op(blse_pkg::BLSE_LOAD_BIT, 1'h0, 4'h0);
		op(blse_pkg::BLSE_FALLING_EDGE_DETECT, 1'h0, 4'h0);
		$display("test edges done");
		// Seven terms pass, the eighth raises the flag until the scan ends
		op(blse_pkg::BLSE_LOAD_BIT, 1'h1, 4'h0);
		repeat (7)
			op(blse_pkg::BLSE_AND_BIT, 1'h1, 4'h0);
		op(blse_pkg::BLSE_OR_NOT_BIT, 1'h0, 4'h0);
		scan_end();
		$display("test terms done");
		for (n = 0; n < 600; n++) begin
			if (n % 40 == 0) begin
				phys_pins = 16'($urandom);
				repeat (3) blse_exec_model_i.idle();
				pins_m = phys_pins;
				check("instr_done", instr_done, 1'h0);
			end
			if (n % 11 == 10)
				scan_end();
			i = blse_pkg::blse_instr_t'($urandom);
			i.edge_idx[3:2] = 2'h0;
			run(i);
		end
		$display("test random done");
		wrap_up();
	end
endmodule // blse_evaluator_test
`default_nettype wire

// file: blse_exec_model.sv
// Behavioural scan executor that feeds the bit-logic stack evaluator.
// Assumes core_clk comes from the bench; all changes land 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module blse_exec_model (
	input  wire logic                  core_clk,
	output var  logic                  instr_valid,
	output var  blse_pkg::blse_instr_t instr,
	output var  logic                  scan_strobe
);
	// ==========================================
	// Issue side
	initial begin
		instr_valid = 1'h0;
		instr = '0;
		scan_strobe = 1'h0;
	end
	// One instruction per cycle, held up to the taking edge
	task automatic issue(input blse_pkg::blse_instr_t i);
		instr = i;
		instr_valid = 1'h1;
		@(posedge core_clk);
		#1;
	endtask
	// Released fields turn over, so a stale word never passes for a live one
	task automatic idle();
		instr_valid = 1'h0;
		instr = blse_pkg::blse_instr_t'(~instr);
		@(posedge core_clk);
		#1;
	endtask
	task automatic strobe();
		instr_valid = 1'h0;
		scan_strobe = 1'h1;
		@(posedge core_clk);
		#1;
		scan_strobe = 1'h0;
	endtask
endmodule // blse_exec_model
`default_nettype wire

// file: blse_pkg.sv
// Package for the bit-logic stack evaluator: opcodes, operand sources, carriers.
// Assumes the executor resolves operand addresses into a bit before issue.
package blse_pkg;

	// ==========================================
	// Sizes
	localparam int EDGE_SLOTS   = 16;
	localparam int EDGE_IDX_W   = 4;
	localparam int PIN_W        = 16;
	localparam int PIN_IDX_W    = 4;
	localparam int MAX_TERMS    = 7;
	localparam int TERM_CNT_W   = 3;
	localparam logic TOS_RESET  = 1'h0;
	localparam logic PREV_RESET = 1'h0;

	// ==========================================
	// Instructions
	typedef enum logic [3:0] {
		BLSE_NOP,
		BLSE_LOAD_BIT,
		BLSE_AND_BIT,
		BLSE_OR_BIT,
		BLSE_LOAD_NOT_BIT,
		BLSE_AND_NOT_BIT,
		BLSE_OR_NOT_BIT,
		BLSE_LOAD_IMMEDIATE,
		BLSE_AND_IMMEDIATE,
		BLSE_OR_IMMEDIATE,
		BLSE_LOAD_INVERTED_IMMEDIATE,
		BLSE_AND_INVERTED_IMMEDIATE,
		BLSE_OR_INVERTED_IMMEDIATE,
		BLSE_INVERT_TOP,
		BLSE_RISING_EDGE_DETECT,
		BLSE_FALLING_EDGE_DETECT
	} blse_op_t;

	// Where a non-immediate operand comes from
	typedef enum logic [1:0] {
		BLSE_SRC_MEMORY,
		BLSE_SRC_INPUT_IMAGE,
		BLSE_SRC_OUTPUT_IMAGE
	} blse_src_t;

	typedef struct packed {
		blse_op_t                op;
		blse_src_t               src;
		logic                    mem_bit;
		logic [PIN_IDX_W-1:0]    pin_idx;
		logic [EDGE_IDX_W-1:0]   edge_idx;
	} blse_instr_t;

	typedef struct packed {
		logic [PIN_W-1:0] input_image;
		logic [PIN_W-1:0] output_image;
	} blse_image_t;

endpackage
